// ===== core/priv_regs.sv
// privilege control, status word, general registers and multiply unit registers
`timescale 1ns/1ps

// Summary of operation
// - one privilege bit in the status word; zero means user level, restricted registers
// - user level refuses privileged instructions
// - supervisor level reaches every register and every instruction
// - supervisor level also sees the system configuration registers
// - every exception and interrupt runs at supervisor level
// - exception return or status write with privilege bit zero enters user level
// - each memory access is tagged supervisor or user space by current level
// - eight 32-bit data registers taking byte, word and long operands
// - eight 32-bit address registers; the eighth is the hardware stack pointer
// - address registers take word and longword operations
// - instruction pointer holds the address of the executing instruction
// - condition flags sit in the status low byte, set by the last operation
// - multiply unit status holds its configuration and result flags
// - multiply sum register accumulates multiply-accumulate results
// - mask register optionally masks multiply operand addresses for circular queues
// - status high byte carries interrupt mask and mode indicators
module priv_regs (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [1:0] reg_size,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire priv_regs_pkg::exec_req_t exec_req,
  input wire priv_regs_pkg::exc_req_t exc_req,
  input wire priv_regs_pkg::ret_req_t ret_req,
  input wire priv_regs_pkg::flag_upd_t flag_upd,
  input wire priv_regs_pkg::mul_req_t mul_req,
  input wire logic [31:0] mul_addr_in,
  input wire logic mem_req,
  input wire logic mem_is_prog,
  output logic sup_mode,
  output logic [4:0] condition_flags,
  output logic priv_fault,
  output logic [31:0] stack_ptr,
  output logic [31:0] instruction_pointer,
  output logic [31:0] mul_addr_out,
  output logic [2:0] mem_space
);
  import priv_regs_pkg::*;

  // ==========================================================================
  // state
  status_word_t status_word_q;
  status_word_t status_word_d;
  mul_status_t mul_status_q;
  mul_status_t mul_status_d;
  logic [31:0] mul_sum_q;
  logic [31:0] mul_sum_d;
  logic [31:0] mul_mask_q;
  logic [31:0] stack_ptr_q;
  logic [31:0] stack_ptr_d;
  logic [31:0] ip_q;
  logic [31:0] vec_base_q;
  logic [31:0] mod_base_q;
  logic priv_fault_q;
  logic [31:0] mul_addr_q;
  logic [2:0] mem_space_q;

  // ==========================================================================
  // register port decode
  wire is_sup = status_word_q.sup;
  wire hit_gpr = (reg_addr[7:6] == 2'h0) && (reg_addr[1:0] == 2'h0);
  wire [3:0] gpr_idx = reg_addr[5:2];
  wire hit_addr_reg = hit_gpr && gpr_idx[3];
  wire hit_sp = hit_gpr && (gpr_idx == STACK_PTR_IDX);

  wire hit_ip = reg_addr == OFS_IP;
  wire hit_status = reg_addr == OFS_STATUS;
  wire hit_mstat = reg_addr == OFS_MUL_STATUS;
  wire hit_msum = reg_addr == OFS_MUL_SUM;
  wire hit_mmask = reg_addr == OFS_MUL_MASK;

  wire hit_vbase = reg_addr == OFS_VEC_BASE;
  wire hit_mbase = reg_addr == OFS_MOD_BASE;
  wire hit_sys_cfg = hit_vbase || hit_mbase;

  // configuration registers exist only for the supervisor view
  wire cfg_refused = hit_sys_cfg && !is_sup;
  wire cfg_ok = hit_sys_cfg && is_sup;
  wire wr_ok = reg_wr && !cfg_refused;

  // ==========================================================================
  // per-register write strobes
  // the status strobe is split by level further down
  wire status_we = reg_wr && hit_status;
  wire msum_we = wr_ok && hit_msum;
  wire mstat_we = wr_ok && hit_mstat;
  wire mmask_we = wr_ok && hit_mmask;
  wire vbase_we = reg_wr && hit_vbase && cfg_ok;
  wire mbase_we = reg_wr && hit_mbase && cfg_ok;
  // a fetch in the same cycle owns the pointer, so the port write is dropped
  wire ip_we = wr_ok && hit_ip && is_sup && !exec_req.valid;

  // ==========================================================================
  // privilege faults and exception entry
  wire op_fault = exec_req.valid && exec_req.privileged && !is_sup;
  wire port_fault = (reg_wr || reg_rd) && cfg_refused;
  wire fault_now = op_fault || port_fault;
  wire take_exc = exc_req.valid || fault_now;
  // a return is itself privileged, so it is only honoured at supervisor level
  wire take_ret = ret_req.valid && is_sup && !take_exc;

  // ==========================================================================
  // general register writes
  wire [31:0] word_sext = {{16{reg_wdata[15]}}, reg_wdata[15:0]};
  // address registers take word (sign extended to 32 bits) and long only
  wire addr_byte = hit_addr_reg && (reg_size == SIZE_BYTE);
  wire [31:0] gpr_wdata = (hit_addr_reg && reg_size == SIZE_WORD) ? word_sext : reg_wdata;
  wire [3:0] data_lanes = (reg_size == SIZE_BYTE) ? LANES_BYTE :
                          (reg_size == SIZE_WORD) ? LANES_WORD : LANES_LONG;
  wire [3:0] gpr_lanes = hit_addr_reg ? LANES_LONG : data_lanes;
  wire gpr_we = reg_wr && hit_gpr && !hit_sp && !addr_byte;
  // the stack pointer lives outside the array so exception entry can step it
  wire sp_we = reg_wr && hit_sp && !addr_byte;
  wire [31:0] sp_framed = stack_ptr_q - FRAME_BYTES;

  // ==========================================================================
  // read path; everything outside the array goes through the alternate input
  wire rd_alt = !hit_gpr || hit_sp;
  wire [31:0] status_word_rd = {16'h0000, status_word_q};
  wire [31:0] mstat_rd = {24'h000000, mul_status_q};
  wire [31:0] alt_rd = hit_sp ? stack_ptr_q :
                       hit_ip ? ip_q :
                       hit_status ? status_word_rd :
                       hit_mstat ? mstat_rd :
                       hit_msum ? mul_sum_q :
                       hit_mmask ? mul_mask_q :
                       (hit_vbase && cfg_ok) ? vec_base_q :
                       (hit_mbase && cfg_ok) ? mod_base_q :
                       WORD_RESET;

  gpr_mem u_gpr_mem (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .we(gpr_we),
    .waddr(gpr_idx),
    .wbe(gpr_lanes),
    .wdata(gpr_wdata),
    .re(reg_rd),
    .raddr(gpr_idx),
    .alt_en(rd_alt),
    .alt_data(alt_rd),
    .rdata(reg_rdata)
  );

  // ==========================================================================
  // hardware stack pointer
  always_comb begin
    stack_ptr_d = stack_ptr_q;
    if (take_exc) begin
      // the exception frame wins over a port write in the same cycle
      stack_ptr_d = sp_framed;
    end else if (sp_we) begin
      stack_ptr_d = gpr_wdata;
    end
  end

  // ==========================================================================
  // status word; priority exception > return > port write > flag update
  wire [15:0] port_status = reg_wdata[15:0];

  always_comb begin
    status_word_d = status_word_q;
    if (flag_upd.valid) begin
      status_word_d.condition_flags = flag_upd.flags;
    end
    if (status_we) begin
      if (is_sup) begin
        // full move into the status word, privilege bit included
        status_word_d = status_word_t'(port_status);
      end else begin
        // user level can only reach the flag byte
        status_word_d.rsv_flags = port_status[7:5];
        status_word_d.condition_flags = port_status[4:0];
      end
    end
    if (take_ret) begin
      status_word_d = ret_req.stacked;
    end
    if (take_exc) begin
      status_word_d.sup = 1'b1;
      status_word_d.trace = 1'b0;
      if (exc_req.valid) begin
        status_word_d.int_mask = exc_req.level;
      end
    end
  end

  // ==========================================================================
  // multiply-accumulate datapath
  // 33-bit sum and difference give the unsigned carry or borrow for free
  wire [32:0] add_full = {1'b0, mul_sum_q} + {1'b0, mul_req.product};
  wire [32:0] sub_full = {1'b0, mul_sum_q} - {1'b0, mul_req.product};
  wire [32:0] acc_full = mul_req.sub ? sub_full : add_full;
  wire [31:0] acc_raw = acc_full[31:0];

  wire opnd_sign = mul_req.sub ? ~mul_req.product[31] : mul_req.product[31];
  wire sovf = (mul_sum_q[31] == opnd_sign) && (acc_raw[31] != mul_sum_q[31]);
  wire uovf = acc_full[32];
  wire acc_ovf = mul_status_q.is_signed ? sovf : uovf;

  wire [31:0] sat_val = mul_status_q.is_signed ? (mul_sum_q[31] ? SAT_NEG : SAT_POS) :
                        (mul_req.sub ? WORD_RESET : SAT_UMAX);
  // saturation trades a wrapped result for a clamped one when enabled
  wire [31:0] acc_res = (acc_ovf && mul_status_q.sat_en) ? sat_val : acc_raw;
  wire acc_neg = acc_res[31];
  wire acc_zero = acc_res == WORD_RESET;

  always_comb begin
    mul_sum_d = mul_sum_q;
    mul_status_d = mul_status_q;
    if (mul_req.valid) begin
      mul_sum_d = acc_res;
      mul_status_d.neg = acc_neg;
      mul_status_d.zero = acc_zero;
      // overflow stays up until software rewrites the status register
      mul_status_d.ovf = mul_status_q.ovf || acc_ovf;
    end
    if (msum_we) begin
      mul_sum_d = reg_wdata;
    end
    if (mstat_we) begin
      mul_status_d = mul_status_t'(reg_wdata[7:0]);
    end
  end

  // ==========================================================================
  // operand address masking and space tagging
  wire [31:0] mul_addr_d = mul_status_q.mask_en ? (mul_addr_in & mul_mask_q) : mul_addr_in;
  wire [2:0] space_d = is_sup ? (mem_is_prog ? SPACE_SUP_PROG : SPACE_SUP_DATA) :
                       (mem_is_prog ? SPACE_USER_PROG : SPACE_USER_DATA);

  // ==========================================================================
  // flops, one register to a block
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      status_word_q <= status_word_t'(STATUS_RESET);
    end else begin
      status_word_q <= status_word_d;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mul_status_q <= mul_status_t'(MUL_STATUS_RESET);
    end else begin
      mul_status_q <= mul_status_d;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mul_sum_q <= WORD_RESET;
    end else begin
      mul_sum_q <= mul_sum_d;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stack_ptr_q <= WORD_RESET;
    end else begin
      stack_ptr_q <= stack_ptr_d;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mul_mask_q <= MUL_MASK_RESET;
    end else if (mmask_we) begin
      mul_mask_q <= reg_wdata;
    end
  end

  // a refused user write never lands here; it faults instead
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      vec_base_q <= WORD_RESET;
    end else if (vbase_we) begin
      vec_base_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mod_base_q <= WORD_RESET;
    end else if (mbase_we) begin
      mod_base_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ip_q <= WORD_RESET;
    end else if (exec_req.valid) begin
      ip_q <= exec_req.ip;
    end else if (ip_we) begin
      ip_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      priv_fault_q <= 1'b0;
    end else begin
      priv_fault_q <= fault_now;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mul_addr_q <= WORD_RESET;
    end else begin
      mul_addr_q <= mul_addr_d;
    end
  end

  // the tag stands until the next access, showing the level last used
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mem_space_q <= SPACE_SUP_PROG;
    end else if (mem_req) begin
      mem_space_q <= space_d;
    end
  end

  // ==========================================================================
  // outputs, each straight from a flop
  assign sup_mode = status_word_q.sup;
  assign condition_flags = status_word_q.condition_flags;
  assign priv_fault = priv_fault_q;
  assign stack_ptr = stack_ptr_q;
  assign instruction_pointer = ip_q;
  assign mul_addr_out = mul_addr_q;
  assign mem_space = mem_space_q;

endmodule : priv_regs

// ===== core/priv_regs_pkg.sv
// shared constants and carrier types for the privilege and user register model
package priv_regs_pkg;

  // ==========================================================================
  // register port offsets (byte addresses)
  localparam logic [7:0] OFS_DATA_BASE = 8'h00;
  localparam logic [7:0] OFS_ADDR_BASE = 8'h20;
  localparam logic [7:0] OFS_IP = 8'h40;
  localparam logic [7:0] OFS_STATUS = 8'h44;
  localparam logic [7:0] OFS_MUL_STATUS = 8'h48;
  localparam logic [7:0] OFS_MUL_SUM = 8'h4c;
  localparam logic [7:0] OFS_MUL_MASK = 8'h50;
  localparam logic [7:0] OFS_VEC_BASE = 8'h60;
  localparam logic [7:0] OFS_MOD_BASE = 8'h64;

  // general register index of the hardware stack pointer
  localparam logic [3:0] STACK_PTR_IDX = 4'hf;

  // ==========================================================================
  // operand sizes on the register port
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  localparam logic [3:0] LANES_BYTE = 4'h1;
  localparam logic [3:0] LANES_WORD = 4'h3;
  localparam logic [3:0] LANES_LONG = 4'hf;

  // ==========================================================================
  // status word: high byte mode and interrupt state, low byte condition flags
  typedef struct packed {
    logic trace;
    logic rsv14;
    logic sup;
    logic master;
    logic rsv11;
    logic [2:0] int_mask;
    logic [2:0] rsv_flags;
    logic [4:0] condition_flags;
  } status_word_t;

  localparam logic [15:0] STATUS_RESET = 16'h2700;

  // multiply unit status: configuration in the top bits, result flags below
  typedef struct packed {
    logic sat_en;
    logic is_signed;
    logic mask_en;
    logic rsv4;
    logic neg;
    logic zero;
    logic ovf;
    logic rsv0;
  } mul_status_t;

  localparam logic [7:0] MUL_STATUS_RESET = 8'h00;
  localparam logic [7:0] MUL_CFG_BITS = 8'he0;
  localparam logic [31:0] MUL_MASK_RESET = 32'hffffffff;
  localparam logic [31:0] WORD_RESET = 32'h00000000;

  // ==========================================================================
  // execution side carriers
  typedef struct packed {
    logic valid;
    logic privileged;
    logic [31:0] ip;
  } exec_req_t;

  typedef struct packed {
    logic valid;
    logic [2:0] level;
  } exc_req_t;

  typedef struct packed {
    logic valid;
    status_word_t stacked;
  } ret_req_t;

  typedef struct packed {
    logic valid;
    logic [4:0] flags;
  } flag_upd_t;

  typedef struct packed {
    logic valid;
    logic sub;
    logic [31:0] product;
  } mul_req_t;

  // address space tags for memory accesses
  localparam logic [2:0] SPACE_USER_DATA = 3'h1;
  localparam logic [2:0] SPACE_USER_PROG = 3'h2;
  localparam logic [2:0] SPACE_SUP_DATA = 3'h5;
  localparam logic [2:0] SPACE_SUP_PROG = 3'h6;

  // bytes pushed onto the hardware stack on exception entry
  localparam logic [31:0] FRAME_BYTES = 32'h00000008;

  localparam logic [31:0] SAT_POS = 32'h7fffffff;
  localparam logic [31:0] SAT_NEG = 32'h80000000;
  localparam logic [31:0] SAT_UMAX = 32'hffffffff;

endpackage : priv_regs_pkg

// ===== core/gpr_mem.sv
// sixteen-word general register store with lane writes and registered read
`timescale 1ns/1ps

module gpr_mem (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [3:0] wbe,
  input wire logic [31:0] wdata,
  input wire logic re,
  input wire logic [3:0] raddr,
  input wire logic alt_en,
  input wire logic [31:0] alt_data,
  output logic [31:0] rdata
);
  import priv_regs_pkg::*;

  logic [31:0] word_rd;

  // ==========================================================================
  // storage, one byte lane per generate step; each lane owns its array
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      logic [7:0] lane_q [16];
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          for (int i = 0; i < 16; i++) begin
            lane_q[i] <= 8'h00;
          end
        end else if (we && wbe[lane]) begin
          lane_q[waddr] <= wdata[lane*8 +: 8];
        end
      end
      assign word_rd[lane*8 +: 8] = lane_q[raddr];
    end
  endgenerate

  // ==========================================================================
  // read register; alternate data lets the owner return non-array values
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= WORD_RESET;
    end else if (re) begin
      rdata <= alt_en ? alt_data : word_rd;
    end
  end

endmodule : gpr_mem

// ===== verif/priv_regs_checker.sv
// concurrent checks on the ports of the privilege and register model
`timescale 1ns/1ps

module priv_regs_checker
  import priv_regs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [1:0] reg_size,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire priv_regs_pkg::exec_req_t exec_req,
  input wire priv_regs_pkg::exc_req_t exc_req,
  input wire priv_regs_pkg::ret_req_t ret_req,
  input wire priv_regs_pkg::flag_upd_t flag_upd,
  input wire priv_regs_pkg::mul_req_t mul_req,
  input wire logic [31:0] mul_addr_in,
  input wire logic mem_req,
  input wire logic mem_is_prog,
  input wire logic sup_mode,
  input wire logic [4:0] condition_flags,
  input wire logic priv_fault,
  input wire logic [31:0] stack_ptr,
  input wire logic [31:0] instruction_pointer,
  input wire logic [31:0] mul_addr_out,
  input wire logic [2:0] mem_space
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // sequences
  sequence user_priv_op;
    exec_req.valid && exec_req.privileged && !sup_mode;
  endsequence

  sequence fault_taken;
    priv_fault && sup_mode;
  endsequence

  // ==========================================================================
  // properties
  reset_sup_a: assert property ($fell(sys_rst) |-> sup_mode && !priv_fault)
    else $error("not supervisor after reset");
  user_fault_a: assert property (user_priv_op |=> fault_taken)
    else $error("privileged op at user did not fault");
  sup_nofault_a: assert property (sup_mode |=> !priv_fault)
    else $error("fault raised at supervisor level");
  exc_entry_a: assert property (exc_req.valid |=> sup_mode && stack_ptr == $past(stack_ptr) - FRAME_BYTES)
    else $error("exception entry wrong");
  ip_load_a: assert property (exec_req.valid |=> instruction_pointer == $past(exec_req.ip))
    else $error("instruction pointer not loaded");
  space_tag_a: assert property (mem_req |=>
    mem_space == {$past(sup_mode), $past(mem_is_prog), !$past(mem_is_prog)})
    else $error("address space tag wrong");
  flag_load_a: assert property (flag_upd.valid && !exc_req.valid && !ret_req.valid && !reg_wr && !exec_req.valid
    |=> condition_flags == $past(flag_upd.flags))
    else $error("condition flags not updated");
  ret_level_a: assert property (ret_req.valid && sup_mode && !exc_req.valid |=> sup_mode == $past(ret_req.stacked.sup)
    && condition_flags == $past(ret_req.stacked.condition_flags))
    else $error("return did not restore status");
  user_stay_a: assert property (!sup_mode && !exc_req.valid && !exec_req.valid && !reg_wr && !reg_rd
    && !ret_req.valid |=> !sup_mode)
    else $error("left user level without cause");
endmodule : priv_regs_checker

bind priv_regs priv_regs_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_size(reg_size), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .exec_req(exec_req), .exc_req(exc_req), .ret_req(ret_req), .flag_upd(flag_upd), .mul_req(mul_req),
  .mul_addr_in(mul_addr_in), .mem_req(mem_req), .mem_is_prog(mem_is_prog), .sup_mode(sup_mode),
  .condition_flags(condition_flags), .priv_fault(priv_fault), .stack_ptr(stack_ptr),
  .instruction_pointer(instruction_pointer), .mul_addr_out(mul_addr_out), .mem_space(mem_space));

// ===== verif/priv_regs_tb.sv
// self-checking testbench for the privilege and register model
`timescale 1ns/1ps

module priv_regs_tb;
  import priv_regs_pkg::*;
  logic clk_sys;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [1:0] reg_size;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  exec_req_t exec_req;
  exc_req_t exc_req;
  ret_req_t ret_req;
  flag_upd_t flag_upd;
  mul_req_t mul_req;
  logic [31:0] mul_addr_in;
  logic mem_req;
  logic mem_is_prog;
  logic sup_mode;
  logic [4:0] condition_flags;
  logic priv_fault;
  logic [31:0] stack_ptr;
  logic [31:0] instruction_pointer;
  logic [31:0] mul_addr_out;
  logic [2:0] mem_space;
  logic [31:0] d;
  int fail_count = 0;
  int num_checks = 0;

  priv_regs DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_size(reg_size), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_req(exec_req),
    .exc_req(exc_req), .ret_req(ret_req), .flag_upd(flag_upd), .mul_req(mul_req), .mul_addr_in(mul_addr_in),
    .mem_req(mem_req), .mem_is_prog(mem_is_prog), .sup_mode(sup_mode), .condition_flags(condition_flags),
    .priv_fault(priv_fault), .stack_ptr(stack_ptr), .instruction_pointer(instruction_pointer),
    .mul_addr_out(mul_addr_out), .mem_space(mem_space));

  // ==========================================================================
  // access tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] s);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_size <= s;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  // ends every execution-side pulse after one taking edge
  task automatic idle();
    @(posedge clk_sys);
    exec_req.valid <= 1'b0;
    exc_req.valid <= 1'b0;
    ret_req.valid <= 1'b0;
    flag_upd.valid <= 1'b0;
    mul_req.valid <= 1'b0;
    mem_req <= 1'b0;
    #1;
  endtask : idle

  task automatic mem(input logic prog, input logic [31:0] exp);
    @(posedge clk_sys);
    mem_req <= 1'b1;
    mem_is_prog <= prog;
    idle();
    chk(mem_space, exp);
  endtask : mem

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // ==========================================================================
  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // the sequence needs about 140 cycles; this is about twenty times that
  initial begin
    #12000;
    fail_count++;
    final_report();
  end

  // ==========================================================================
  // scenarios
  initial begin
    sys_rst = 1'b1;
    {reg_addr, reg_wdata, reg_size, reg_wr, reg_rd} = '0;
    {exec_req, exc_req, ret_req, flag_upd, mul_req} = '0;
    {mul_addr_in, mem_req, mem_is_prog} = '0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk(sup_mode, 32'h1);
    chk(stack_ptr, 32'h0);
    chk(mem_space, 32'h6);
    rd(OFS_STATUS, d); chk(d, 32'h2700);
    rd(OFS_MUL_MASK, d); chk(d, 32'hffffffff);
    // data registers keep the bits above the operand size
    wr(OFS_DATA_BASE + 8'h04, 32'h11223344, SIZE_LONG);
    wr(OFS_DATA_BASE + 8'h04, 32'h000000aa, SIZE_BYTE);
    rd(OFS_DATA_BASE + 8'h04, d); chk(d, 32'h112233aa);
    wr(OFS_DATA_BASE + 8'h04, 32'h0000bbcc, SIZE_WORD);
    rd(OFS_DATA_BASE + 8'h04, d); chk(d, 32'h1122bbcc);
    wr(OFS_DATA_BASE + 8'h1c, 32'hcafef00d, 2'h3);
    rd(OFS_DATA_BASE + 8'h1c, d); chk(d, 32'hcafef00d);
    rd(OFS_DATA_BASE, d); chk(d, 32'h0);
    wr(OFS_ADDR_BASE + 8'h04, 32'h00008001, SIZE_WORD);
    wr(OFS_ADDR_BASE + 8'h04, 32'h00000055, SIZE_BYTE);
    rd(OFS_ADDR_BASE + 8'h04, d); chk(d, 32'hffff8001);
    wr(OFS_ADDR_BASE + 8'h1c, 32'h00001000, SIZE_LONG);
    chk(stack_ptr, 32'h1000);
    wr(8'h7c, 32'h00001234, SIZE_LONG);
    rd(8'h7c, d); chk(d, 32'h0);
    wr(OFS_VEC_BASE, 32'h00100000, SIZE_LONG);
    rd(OFS_VEC_BASE, d); chk(d, 32'h00100000);
    wr(OFS_MOD_BASE, 32'h10000001, SIZE_LONG);
    rd(OFS_MOD_BASE, d); chk(d, 32'h10000001);
    chk(priv_fault, 32'h0);
    mem(1'b0, 32'h5);
    mem(1'b1, 32'h6);
    @(posedge clk_sys);
    exc_req <= {1'b1, 3'h3};
    idle();
    chk(stack_ptr, 32'h0ff8);
    rd(OFS_STATUS, d); chk(d, 32'h2300);
    @(posedge clk_sys);
    flag_upd <= {1'b1, 5'h15};
    idle();
    chk(condition_flags, 32'h15);
    rd(OFS_STATUS, d); chk(d, 32'h2315);
    // user level: only the low byte of the status word is writable
    wr(OFS_STATUS, 32'h0, SIZE_LONG);
    chk(sup_mode, 32'h0);
    mem(1'b0, 32'h1);
    mem(1'b1, 32'h2);
    wr(OFS_STATUS, 32'h00002711, SIZE_LONG);
    rd(OFS_STATUS, d); chk(d, 32'h0011);
    wr(OFS_VEC_BASE, 32'hfff00000, SIZE_LONG);
    chk(priv_fault, 32'h1);
    chk(stack_ptr, 32'h0ff0);
    rd(OFS_VEC_BASE, d); chk(d, 32'h00100000);
    wr(OFS_STATUS, 32'h0, SIZE_LONG);
    rd(OFS_VEC_BASE, d); chk(d, 32'h0);
    chk(priv_fault, 32'h1);
    wr(OFS_STATUS, 32'h0, SIZE_LONG);
    @(posedge clk_sys);
    exec_req <= {1'b1, 1'b0, 32'h00004000};
    idle();
    chk(instruction_pointer, 32'h4000);
    chk({priv_fault, sup_mode}, 32'h0);
    @(posedge clk_sys);
    exec_req <= {1'b1, 1'b1, 32'h00004004};
    idle();
    chk({priv_fault, sup_mode}, 32'h3);
    chk(instruction_pointer, 32'h4004);
    chk(stack_ptr, 32'h0fe0);
    @(posedge clk_sys);
    ret_req <= {1'b1, 16'h0004};
    idle();
    chk({sup_mode, condition_flags}, 32'h04);
    @(posedge clk_sys);
    ret_req <= {1'b1, 16'h2700};
    idle();
    chk(sup_mode, 32'h0);
    // multiply unit is reachable from user level
    wr(OFS_MUL_STATUS, 32'h40, SIZE_LONG);
    wr(OFS_MUL_SUM, 32'h0f, SIZE_LONG);
    @(posedge clk_sys);
    mul_req <= {1'b1, 1'b0, 32'h5};
    idle();
    rd(OFS_MUL_SUM, d); chk(d, 32'h14);
    @(posedge clk_sys);
    mul_req <= {1'b1, 1'b1, 32'h19};
    idle();
    rd(OFS_MUL_SUM, d); chk(d, 32'hfffffffb);
    rd(OFS_MUL_STATUS, d); chk(d, 32'h48);
    wr(OFS_MUL_STATUS, 32'hc0, SIZE_LONG);
    wr(OFS_MUL_SUM, 32'h7ffffff0, SIZE_LONG);
    @(posedge clk_sys);
    mul_req <= {1'b1, 1'b0, 32'h100};
    mul_addr_in <= 32'h1234abcd;
    idle();
    rd(OFS_MUL_SUM, d); chk(d, 32'h7fffffff);
    rd(OFS_MUL_STATUS, d); chk(d, 32'hc2);
    chk(mul_addr_out, 32'h1234abcd);
    // unsigned saturation clamps a borrow at zero
    wr(OFS_MUL_STATUS, 32'h80, SIZE_LONG);
    wr(OFS_MUL_SUM, 32'h10, SIZE_LONG);
    @(posedge clk_sys);
    mul_req <= {1'b1, 1'b1, 32'h20};
    idle();
    rd(OFS_MUL_SUM, d); chk(d, 32'h0);
    rd(OFS_MUL_STATUS, d); chk(d, 32'h86);
    wr(OFS_MUL_MASK, 32'h0000ffff, SIZE_LONG);
    wr(OFS_MUL_STATUS, 32'he0, SIZE_LONG);
    @(posedge clk_sys);
    #1;
    chk(mul_addr_out, 32'h0000abcd);
    // second reset in mid-run
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk(sup_mode, 32'h1);
    rd(OFS_MUL_SUM, d); chk(d, 32'h0);
    rd(OFS_STATUS, d); chk(d, 32'h2700);
    final_report();
  end
endmodule : priv_regs_tb
